//--- pkg/spg_defs.vh
// Constants for the speed PI gain scheduler: register offsets, field positions and reset values.
// Assumes the including file uses the names only; no logic lives here.
`ifndef SPG_DEFS_VH
`define SPG_DEFS_VH

// ****************************************************************
// Register word offsets (byte address = offset, aligned words)
// ****************************************************************
`define SPG_ADR_P_PCT        8'h00
`define SPG_ADR_I_PCT        8'h04
`define SPG_ADR_P_BASE       8'h08
`define SPG_ADR_I_BASE       8'h0C
`define SPG_ADR_P_INUSE      8'h10
`define SPG_ADR_I_INUSE      8'h14
`define SPG_ADR_P_FILT       8'h18
`define SPG_ADR_REF0_LVL     8'h1C
`define SPG_ADR_Z_P_PCT      8'h20
`define SPG_ADR_CTRL         8'h24
`define SPG_ADR_SPD0_LVL     8'h28
`define SPG_ADR_SPD0_DLY     8'h2C
`define SPG_ADR_STATUS       8'h30
`define SPG_ADR_KP_OUT       8'h34
`define SPG_ADR_KI_OUT       8'h38

// ****************************************************************
// Control register fields
// ****************************************************************
`define SPG_CTRL_ZP_EN       0
`define SPG_CTRL_ZI_EN       1
`define SPG_CTRL_HOLD_EN     2
`define SPG_CTRL_RAMP_EN     3

// ****************************************************************
// Status register fields
// ****************************************************************
`define SPG_ST_REF0          0
`define SPG_ST_SPD0          1
`define SPG_ST_ZGAIN         2

// ****************************************************************
// Reset values and the percent divisor
// ****************************************************************
`define SPG_RST_PCT          16'h0064
`define SPG_RST_BASE         16'h0100
`define SPG_RST_ZERO16       16'h0000
`define SPG_RST_FILT         4'h0
`define SPG_RST_CTRL         4'h0
`define SPG_PCT_DIV          16'h0064

`endif

//--- core/spg_zero_det.v
// Speed-near-zero detector with a qualifying delay in control ticks.
// Assumes speed magnitude and tick come from logic on the same clock.
`timescale 1ns/100ps
module spg_zero_det
#(
  parameter W  = 16,
  parameter DW = 16
)
(
  // Clock and control
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          ce_i,
  input  wire          tick_i,
  // Comparison
  input  wire [W-1:0]  spd_mag_i,
  input  wire [W-1:0]  level_i,
  input  wire [DW-1:0] delay_i,
  output reg           zero_o
);

  reg [DW-1:0] cnt_r;

  // The flag rises only after the speed stayed low for the delay (see RULE_11).
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r  <= {DW{1'b0}};
      zero_o <= 1'b0;
    end
    else if (ce_i && tick_i)
    begin
      if (spd_mag_i >= level_i)
      begin
        cnt_r  <= {DW{1'b0}};
        zero_o <= 1'b0;
      end
      else if (cnt_r >= delay_i)
        zero_o <= 1'b1;
      else
        cnt_r <= cnt_r + {{(DW-1){1'b0}}, 1'b1};
    end
  end
endmodule

//--- core/spg_lpf.v
// First-order low-pass filter by shift: y += (x - y) >> shift, once per tick.
// Assumes signed input from the same clock; shift zero passes the input through.
`timescale 1ns/100ps
module spg_lpf
#(
  parameter W = 24
)
(
  // Clock and control
  input  wire                clk_i,
  input  wire                rst_i,
  input  wire                ce_i,
  input  wire                tick_i,
  // Data
  input  wire [3:0]          shift_i,
  input  wire signed [W-1:0] x_i,
  output reg  signed [W-1:0] y_o
);

  wire signed [W:0] diff_w;
  wire signed [W:0] step_w;

  assign diff_w = {x_i[W-1], x_i} - {y_o[W-1], y_o};
  assign step_w = diff_w >>> shift_i;

  // The time constant grows as a power of two of the tick period (see RULE_06).
  always @(posedge clk_i)
  begin
    if (rst_i)
      y_o <= {W{1'b0}};
    else if (ce_i && tick_i)
      y_o <= y_o + step_w[W-1:0];
  end
endmodule

//--- core/spg_top.v
// Gain scheduler for a PI speed regulator, with a classic Wishbone register slave.
// Assumes tick, speed, references and proportional error come from logic on clk_i.
//
// Behaviour
// RULE_01 - Standard P gain is a percentage times the base P coefficient.
// RULE_02 - Standard I gain is a percentage times the base I coefficient.
// RULE_03 - Base P coefficient, A/rpm, scales every proportional percentage.
// RULE_04 - Base I coefficient, A/rpm-ms, scales every integral percentage.
// RULE_05 - Read-only in-use P and I percentages equal standard when nothing special.
// RULE_06 - Proportional action passes a low-pass filter of configurable time constant.
// RULE_07 - Reference-near-zero flag while selected reference (ramp or raw) below level.
// RULE_08 - Zero-speed P percentage applies only while its enable is on.
// RULE_09 - With zero-speed I enable, I gain zero while both flags assert.
// RULE_10 - With zero-speed I enable off, I gain stays active at standstill. Here I gain is still zero in zero-speed mode (zero-speed P enable on).
// RULE_11 - Speed-near-zero flag asserts after speed stays below level for delay.
// RULE_12 - Hold on: enter zero gains on both flags, leave when reference rises.
// RULE_13 - Hold off: zero gains need both speed and reference conditions.
// RULE_14 - Software should enable hold only with zero-speed P enable on.
// RULE_15 - Zero-speed P enable: zero-speed P and zero I while both flags assert.
// RULE_16 - Priority: bypass, zero-speed, adaptive, standard; last only if none else. Only zero-speed and standard are built here.
// RULE_17 - Selection and monitors update every control tick.
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
`include "spg_defs.vh"
module spg_top
#(
  parameter W = 16
)
(
  // Clock, reset, enable
  input  wire              clk_i,
  input  wire              rst_i,
  input  wire              ce_i,
  // Wishbone slave
  input  wire              cyc_i,
  input  wire              stb_i,
  input  wire              we_i,
  input  wire [7:0]        adr_i,
  input  wire [3:0]        sel_i,
  input  wire [31:0]       dat_i,
  output reg  [31:0]       dat_o,
  output reg               ack_o,
  // Regulator side
  input  wire              tick_i,
  input  wire [W-1:0]      spd_mag_i,
  input  wire [W-1:0]      ref_raw_mag_i,
  input  wire [W-1:0]      ref_ramp_mag_i,
  input  wire signed [W-1:0] perr_i,
  // Gains, proportional action and flags
  output reg  [31:0]       kp_o,
  output reg  [31:0]       ki_o,
  output reg  signed [2*W+7:0] pact_o,
  output reg               ref0_o,
  output reg               spd0_o
);

  localparam PW = 2 * W + 8;

  // One-hot gain modes.
  localparam [1:0] ST_STD  = 2'b01;
  localparam [1:0] ST_ZERO = 2'b10;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [W-1:0] p_pct_r;
  reg  [W-1:0] i_pct_r;
  reg  [W-1:0] p_base_r;
  reg  [W-1:0] i_base_r;
  reg  [3:0]   p_filt_r;
  reg  [W-1:0] ref0_lvl_r;
  reg  [W-1:0] z_p_pct_r;
  reg  [3:0]   ctrl_r;
  reg  [W-1:0] spd0_lvl_r;
  reg  [W-1:0] spd0_dly_r;
  reg  [W-1:0] p_inuse_r;
  reg  [W-1:0] i_inuse_r;
  reg          zgain_r;
  reg  [W-1:0] p_inuse_nxt;
  reg  [W-1:0] i_inuse_nxt;
  reg          zgain_nxt;
  reg  [1:0]   st_r;
  reg  [1:0]   st_nxt;
  reg  [31:0]  rd_nxt;
  wire         spd0_w;
  wire         ref0_w;
  wire [W-1:0] ref_sel_w;
  wire [31:0]  kp_nxt;
  wire [31:0]  ki_nxt;
  wire signed [PW-1:0] praw_w;
  wire signed [PW-1:0] pfilt_w;
  wire         wr_w;
  wire         zp_en_w;
  wire         zi_en_w;
  wire         hold_en_w;
  wire         both0_w;

  // A write lands at the edge at which the master samples ack high.
  assign wr_w = cyc_i && stb_i && we_i && ack_o;

  // ****************************************************************
  // Wishbone slave: one wait state, ack for one cycle
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= rd_nxt;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      p_pct_r    <= `SPG_RST_PCT;
      i_pct_r    <= `SPG_RST_PCT;
      p_base_r   <= `SPG_RST_BASE;
      i_base_r   <= `SPG_RST_BASE;
      p_filt_r   <= `SPG_RST_FILT;
      ref0_lvl_r <= `SPG_RST_ZERO16;
      z_p_pct_r  <= `SPG_RST_ZERO16;
      ctrl_r     <= `SPG_RST_CTRL;
      spd0_lvl_r <= `SPG_RST_ZERO16;
      spd0_dly_r <= `SPG_RST_ZERO16;
    end
    else if (ce_i)
    begin
      if (wr_w && sel_i[0] && sel_i[1])
      begin
        case (adr_i)
          `SPG_ADR_P_PCT:    p_pct_r    <= dat_i[W-1:0];
          `SPG_ADR_I_PCT:    i_pct_r    <= dat_i[W-1:0];
          `SPG_ADR_P_BASE:   p_base_r   <= dat_i[W-1:0];
          `SPG_ADR_I_BASE:   i_base_r   <= dat_i[W-1:0];
          `SPG_ADR_P_FILT:   p_filt_r   <= dat_i[3:0];
          `SPG_ADR_REF0_LVL: ref0_lvl_r <= dat_i[W-1:0];
          `SPG_ADR_Z_P_PCT:  z_p_pct_r  <= dat_i[W-1:0];
          `SPG_ADR_CTRL:     ctrl_r     <= dat_i[3:0];
          `SPG_ADR_SPD0_LVL: spd0_lvl_r <= dat_i[W-1:0];
          `SPG_ADR_SPD0_DLY: spd0_dly_r <= dat_i[W-1:0];
          default:           ctrl_r     <= ctrl_r;
        endcase
      end
    end
  end

  // Unmapped addresses read zero and ignore writes; the in-use words are read only.
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (adr_i)
      `SPG_ADR_P_PCT:    rd_nxt[W-1:0] = p_pct_r;
      `SPG_ADR_I_PCT:    rd_nxt[W-1:0] = i_pct_r;
      `SPG_ADR_P_BASE:   rd_nxt[W-1:0] = p_base_r;
      `SPG_ADR_I_BASE:   rd_nxt[W-1:0] = i_base_r;
      `SPG_ADR_P_INUSE:  rd_nxt[W-1:0] = p_inuse_r; // see RULE_05
      `SPG_ADR_I_INUSE:  rd_nxt[W-1:0] = i_inuse_r; // see RULE_05
      `SPG_ADR_P_FILT:   rd_nxt[3:0]   = p_filt_r;
      `SPG_ADR_REF0_LVL: rd_nxt[W-1:0] = ref0_lvl_r;
      `SPG_ADR_Z_P_PCT:  rd_nxt[W-1:0] = z_p_pct_r;
      `SPG_ADR_CTRL:     rd_nxt[3:0]   = ctrl_r;
      `SPG_ADR_SPD0_LVL: rd_nxt[W-1:0] = spd0_lvl_r;
      `SPG_ADR_SPD0_DLY: rd_nxt[W-1:0] = spd0_dly_r;
      `SPG_ADR_STATUS:   rd_nxt[2:0]   = {zgain_r, spd0_o, ref0_o};
      `SPG_ADR_KP_OUT:   rd_nxt        = kp_o;
      `SPG_ADR_KI_OUT:   rd_nxt        = ki_o;
      default:           rd_nxt        = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // Near-zero detection
  // ****************************************************************
  spg_zero_det
  #(
    .W  (W),
    .DW (W)
  )
  u_spd0
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .tick_i    (tick_i),
    .spd_mag_i (spd_mag_i),
    .level_i   (spd0_lvl_r),
    .delay_i   (spd0_dly_r),
    .zero_o    (spd0_w)
  );

  assign ref_sel_w = ctrl_r[`SPG_CTRL_RAMP_EN] ? ref_ramp_mag_i : ref_raw_mag_i; // see RULE_07
  // Strictly below the level, so a level of zero never raises the flag.
  assign ref0_w    = ref_sel_w < ref0_lvl_r; // see RULE_07

  // ****************************************************************
  // Gain selection
  // ****************************************************************
  assign zp_en_w   = ctrl_r[`SPG_CTRL_ZP_EN]; // see RULE_08
  assign zi_en_w   = ctrl_r[`SPG_CTRL_ZI_EN];
  assign hold_en_w = ctrl_r[`SPG_CTRL_HOLD_EN];
  assign both0_w   = ref0_w && spd0_w;

  // With hold on, only the reference or clearing the zero-speed P enable can end zero-speed mode, so a shaft that
  // creeps above the speed level does not bring the integral gain back.
  always @*
  begin
    st_nxt = ST_STD;
    case (st_r)
      ST_STD:
      begin
        if (zp_en_w && both0_w) // see RULE_15
          st_nxt = ST_ZERO;
      end
      ST_ZERO:
      begin
        if (zp_en_w && hold_en_w && ref0_w) // see RULE_12
          st_nxt = ST_ZERO;
        else if (zp_en_w && both0_w) // see RULE_13
          st_nxt = ST_ZERO;
      end
      default:
        st_nxt = ST_STD;
    endcase
  end

  // Bypass and adaptive sources are not built here, so zero-speed gains
  // outrank the standard settings directly.
  always @*
  begin
    zgain_nxt   = (st_nxt == ST_ZERO);
    p_inuse_nxt = p_pct_r; // see RULE_01
    i_inuse_nxt = i_pct_r; // see RULE_02
    if (zgain_nxt) // see RULE_16
    begin
      p_inuse_nxt = z_p_pct_r; // see RULE_15
      i_inuse_nxt = {W{1'b0}};
    end
    else if (zi_en_w && both0_w)
      i_inuse_nxt = {W{1'b0}}; // see RULE_09
    // With the integral enable off and outside zero-speed mode, the standard I percentage stays in force (see RULE_10).
  end

  // Percent times base over one hundred gives the engineering gain (see RULE_03, RULE_04).
  assign kp_nxt = ({16'h0000, p_inuse_r} * {16'h0000, p_base_r}) / {16'h0000, `SPG_PCT_DIV};
  assign ki_nxt = ({16'h0000, i_inuse_r} * {16'h0000, i_base_r}) / {16'h0000, `SPG_PCT_DIV};

  // Only the low bits of kp_o feed the multiplier: software keeps percent times
  // base small enough that the gain fits, trading range for a narrower product.
  assign praw_w = $signed(kp_o[W+7:0]) * perr_i;

  spg_lpf
  #(
    .W (PW)
  )
  u_plpf
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .tick_i  (tick_i),
    .shift_i (p_filt_r),
    .x_i     (praw_w),
    .y_o     (pfilt_w)
  );

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      p_inuse_r <= `SPG_RST_PCT;
      i_inuse_r <= `SPG_RST_PCT;
      zgain_r   <= 1'b0;
      st_r      <= ST_STD;
      kp_o      <= 32'h00000000;
      ki_o      <= 32'h00000000;
      pact_o    <= {PW{1'b0}};
      ref0_o    <= 1'b0;
      spd0_o    <= 1'b0;
    end
    else if (ce_i && tick_i) // see RULE_17
    begin
      p_inuse_r <= p_inuse_nxt;
      i_inuse_r <= i_inuse_nxt;
      zgain_r   <= zgain_nxt;
      st_r      <= st_nxt;
      kp_o      <= kp_nxt;
      ki_o      <= ki_nxt;
      pact_o    <= pfilt_w; // see RULE_06
      ref0_o    <= ref0_w;
      spd0_o    <= spd0_w;
    end
  end
endmodule

//--- tb/spg_monitor.sv
// Port checker for the speed PI gain scheduler.
// Assumes ce_i stays high while the bus or the tick is in use.
`timescale 1ns/100ps
module spg_monitor
#(
  parameter W = 16
)
(
  // Clock, reset, enable
  input wire                  clk_i,
  input wire                  rst_i,
  input wire                  ce_i,
  // Bus
  input wire                  cyc_i,
  input wire                  stb_i,
  input wire                  ack_o,
  // Regulator side
  input wire                  tick_i,
  input wire [31:0]           kp_o,
  input wire [31:0]           ki_o,
  input wire signed [2*W+7:0] pact_o,
  input wire                  ref0_o,
  input wire                  spd0_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A request that the slave has not answered yet.
  sequence req_s;
    cyc_i && stb_i && !ack_o && ce_i;
  endsequence
  // The previous edge was a real tick, not a reset.
  sequence tick_s;
    $past(tick_i && ce_i) && !$past(rst_i);
  endsequence
  bus_ack_a: assert property (req_s |=> ack_o)
    else $error("request not answered after one cycle");
  ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without a request");
  kp_tick_a: assert property (!$past(rst_i) && $changed(kp_o) |-> tick_s)
    else $error("kp changed without a tick");
  ki_tick_a: assert property (!$past(rst_i) && $changed(ki_o) |-> tick_s)
    else $error("ki changed without a tick");
  pact_tick_a: assert property (!$past(rst_i) && $changed(pact_o) |-> tick_s)
    else $error("proportional action changed without a tick");
  ref0_tick_a: assert property (!$past(rst_i) && $changed(ref0_o) |-> tick_s)
    else $error("reference flag changed without a tick");
  spd0_tick_a: assert property ($rose(spd0_o) |-> tick_s)
    else $error("speed flag rose without a tick");
  reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && kp_o == 32'h00000000 &&
    ki_o == 32'h00000000 && !ref0_o && !spd0_o)
    else $error("outputs not cleared by reset");
endmodule

//--- tb/spg_top_tb.sv
// Self-checking bench for the gain scheduler: Wishbone tasks and tick pulses.
// Assumes the register map and reset values of spg_defs.vh.
`timescale 1ns/100ps
`include "spg_defs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module spg_top_tb;
  reg               clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, tick_i;
  reg [7:0]         adr_i;
  reg [3:0]         sel_i;
  reg [31:0]        dat_i;
  reg [15:0]        spd_mag_i, ref_raw_mag_i, ref_ramp_mag_i;
  reg signed [15:0] perr_i;
  wire [31:0]       dat_o, kp_o, ki_o;
  wire              ack_o, ref0_o, spd0_o;
  wire signed [39:0] pact_o;
  int               n_errors, cmp_count, cyc_n, i;
  logic [31:0]      rd_v;
  logic [31:0]      md[5] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h5};
  logic [31:0]      ep[5] = '{32'h32, 32'h14, 32'h32, 32'h14, 32'h14};
  logic [31:0]      ei[5] = '{32'hC8, 32'h0, 32'h0, 32'h0, 32'h0};
  spg_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .tick_i(tick_i), .spd_mag_i(spd_mag_i), .ref_raw_mag_i(ref_raw_mag_i),
    .ref_ramp_mag_i(ref_ramp_mag_i), .perr_i(perr_i), .kp_o(kp_o), .ki_o(ki_o),
    .pact_o(pact_o), .ref0_o(ref0_o), .spd0_o(spd0_o));
  initial begin clk_i = 0; forever #5 clk_i = ~clk_i; end
  // The whole run needs well under a thousand cycles.
  always @(posedge clk_i) begin cyc_n++; if (cyc_n > 5000) begin n_errors++; end_of_test; end end
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task acc(input bit w, input [7:0] a, input [31:0] d, input [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd_v = dat_o;
    cyc_i <= 0; stb_i <= 0; we_i <= 0;
  endtask
  task wr(input [7:0] a, input [31:0] d); acc(1, a, d, 4'hF); endtask
  task rd(input [7:0] a, input [31:0] e); acc(0, a, 32'h0, 4'hF); `CHK(rd_v, e) endtask
  task tk(input int n);
    repeat (n) begin @(posedge clk_i) tick_i <= 1; @(posedge clk_i) tick_i <= 0; end
    @(posedge clk_i);
  endtask
  initial begin
    {cyc_i, stb_i, we_i, tick_i, adr_i, dat_i} = 0; rst_i = 1; ce_i = 1; sel_i = 4'hF;
    spd_mag_i = 16'h100; ref_raw_mag_i = 16'h100; ref_ramp_mag_i = 16'h100; perr_i = 16'h4;
    n_errors = 0; cmp_count = 0; cyc_n = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    tk(2);
    rd(`SPG_ADR_P_PCT, 32'h64);
    rd(`SPG_ADR_I_BASE, 32'h100);
    rd(8'h3C, 32'h0);
    wr(`SPG_ADR_P_INUSE, 32'h7);
    acc(1, `SPG_ADR_P_PCT, 32'h11, 4'h1);
    rd(`SPG_ADR_P_PCT, 32'h64);
    rd(`SPG_ADR_P_INUSE, 32'h64);
    `CHK(kp_o, 32'h100)
    $display("test reset done");
    wr(`SPG_ADR_P_PCT, 32'h32); wr(`SPG_ADR_P_BASE, 32'h200);
    wr(`SPG_ADR_I_PCT, 32'hC8); wr(`SPG_ADR_I_BASE, 32'h10);
    tk(4);
    `CHK(kp_o, 32'h100)
    `CHK(ki_o, 32'h20)
    rd(`SPG_ADR_I_INUSE, 32'hC8);
    `CHK(pact_o, 40'h400)
    wr(`SPG_ADR_P_FILT, 32'h2); perr_i <= 16'h40; tk(2);
    `CHK(pact_o, 40'h1300)
    wr(`SPG_ADR_P_FILT, 32'h0); tk(2);
    `CHK(pact_o, 40'h4000)
    $display("test gains done");
    wr(`SPG_ADR_REF0_LVL, 32'h10); ref_raw_mag_i <= 16'h5; tk(2);
    `CHK(ref0_o, 1'b1)
    wr(`SPG_ADR_CTRL, 32'h8); tk(2);
    `CHK(ref0_o, 1'b0)
    ref_ramp_mag_i <= 16'h5; tk(2);
    rd(`SPG_ADR_STATUS, 32'h1);
    wr(`SPG_ADR_SPD0_LVL, 32'h10); wr(`SPG_ADR_SPD0_DLY, 32'h3); spd_mag_i <= 16'h5; tk(1);
    `CHK(spd0_o, 1'b0)
    tk(6);
    `CHK(spd0_o, 1'b1)
    $display("test flags done");
    wr(`SPG_ADR_Z_P_PCT, 32'h14);
    for (i = 0; i < 5; i++) begin
      wr(`SPG_ADR_CTRL, md[i]); tk(2);
      rd(`SPG_ADR_P_INUSE, ep[i]);
      rd(`SPG_ADR_I_INUSE, ei[i]);
    end
    `CHK(kp_o, 32'h66)
    spd_mag_i <= 16'h100; tk(8);
    rd(`SPG_ADR_P_INUSE, 32'h14);
    wr(`SPG_ADR_CTRL, 32'h1); tk(2);
    rd(`SPG_ADR_P_INUSE, 32'h32);
    wr(`SPG_ADR_CTRL, 32'h5); spd_mag_i <= 16'h5; tk(8);
    rd(`SPG_ADR_I_INUSE, 32'h0);
    ref_raw_mag_i <= 16'h100; tk(2);
    rd(`SPG_ADR_P_INUSE, 32'h32);
    rd(`SPG_ADR_I_INUSE, 32'hC8);
    $display("test zero speed done");
    ce_i <= 0; ref_raw_mag_i <= 16'h5; tk(2);
    `CHK(ref0_o, 1'b0)
    ce_i <= 1; tk(2);
    `CHK(ref0_o, 1'b1)
    $display("test enable done");
    end_of_test;
  end
endmodule
bind spg_top spg_monitor #(.W(W)) mon_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .tick_i(tick_i), .kp_o(kp_o), .ki_o(ki_o),
  .pact_o(pact_o), .ref0_o(ref0_o), .spd0_o(spd0_o));
